// >>> rtl/rxdsr_consts.vh
// Summary of operation
// - SRAM data register keeps one byte in bits 7:0; bits 15:8 read zero.
// - Delay readout shows the selected delay in cells, guardband included.
// - Readout is 11-bit two's complement, sign copied to 15:11, read-only, resets 0x0004.
// - Link number bits 3:0 give the link of the readout; invalid for max over time.
// - Link number bit 5 set grants host test access to the SRAM.
// - Eight per-group 14-bit guardband/delta counts, each reset to 0x0004.
// - SRAM address is 20 bits: 19:16 from one register, 15:0 from another.
// - Writing 1 to config bit 7 resets the receiver; 0 does nothing.
// - Writing 1 to config bit 6 resets the transmitter; 0 does nothing.
// - Writing 1 to config bit 5 resets the counters.
// - Config bit 8 selects the memory-optimised layout.
// - Config bits 2:0 select receive memory size and bank count.
// - Ones on config bits 7:5 in one write give a global soft reset.
// - Two-bit selector picks max over time, group max, group min or link delay.
// - Access control 1x no access, 00 initialise RAM, 01 single read or write.
`ifndef RXDSR_CONSTS_VH
`define RXDSR_CONSTS_VH
`define RXDSR_ADDR_ACCESS_CTRL 12'h280
`define RXDSR_ADDR_DATA 12'h284
`define RXDSR_ADDR_DELAY 12'h285
`define RXDSR_ADDR_LINKNUM 12'h286
`define RXDSR_ADDR_GB_FIRST 12'h287
`define RXDSR_ADDR_GB_LAST 12'h28E
`define RXDSR_ADDR_ADR_HIGH 12'h297
`define RXDSR_ADDR_ADR_LOW 12'h298
`define RXDSR_ADDR_CONFIG 12'h299
`define RXDSR_ADDR_DELAY_SEL 12'h2AA
`define RXDSR_RST_DELAY 16'h0004
`define RXDSR_RST_GB 14'h0004
`define RXDSR_BIT_TEST_EN 5
`define RXDSR_BIT_DIR 5
`define RXDSR_BIT_OPT 8
`define RXDSR_BIT_RXRST 7
`define RXDSR_BIT_TXRST 6
`define RXDSR_BIT_CNTRST 5
`define RXDSR_MEM_1X32K 3'h0
`define RXDSR_MEM_2X32K 3'h1
`define RXDSR_MEM_1X128K 3'h2
`define RXDSR_MEM_2X128K 3'h3
`define RXDSR_MEM_1X512K 3'h4
`define RXDSR_MEM_2X512K 3'h5
`endif

// >>> rtl/rxdsr_regs.v
`timescale 1ns/10ps
`include "rxdsr_consts.vh"
module rxdsr_regs (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// Host register port
	input wire [11:0] hostAddr,
	input wire [15:0] hostWrData,
	input wire hostWrStrobe,
	input wire hostRdStrobe,
	output wire [15:0] hostRdData,
	output wire hostRdValid,
	// Recombiner delay status
	input wire [10:0] rawDelay,
	input wire [3:0] rawDelayLink,
	input wire [2:0] rawDelayGroup,
	output wire [1:0] delayKind,
	output wire [3:0] delayIndex,
	output wire [111:0] guardbandFlat,
	// Configuration and soft resets
	output wire [2:0] memSize,
	output wire memOptimise,
	output wire rxSoftReset,
	output wire txSoftReset,
	output wire counterSoftReset,
	output wire globalSoftReset,
	output wire sramTestMode,
	// External receive SRAM
	output wire [19:0] sramAddr,
	output wire sramCe_n,
	output wire sramWe_n,
	output wire sramOe_n,
	output wire [7:0] sramDataOut,
	output wire sramDataOe_n,
	input wire [7:0] sramDataIn,
	output wire sramBusy
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_ACC = 4'b0010;
	localparam ST_CAP = 4'b0100;
	localparam ST_INIT = 4'b1000;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [19:0] memLast;
		input [2:0] code;
		begin
			case (code)
				`RXDSR_MEM_2X32K: memLast = 20'h0FFFF;
				`RXDSR_MEM_1X128K: memLast = 20'h1FFFF;
				`RXDSR_MEM_2X128K: memLast = 20'h3FFFF;
				`RXDSR_MEM_1X512K: memLast = 20'h7FFFF;
				`RXDSR_MEM_2X512K: memLast = 20'hFFFFF;
				default: memLast = 20'h07FFF;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [15:0] rdData_reg;
	reg rdValid_reg;
	reg [7:0] data_reg;
	reg [15:0] delay_reg;
	reg [3:0] link_reg;
	reg [4:0] linkCtl_reg;
	reg [111:0] gb_reg;
	reg [3:0] adrHigh_reg;
	reg [15:0] adrLow_reg;
	reg [5:0] cfg_reg;
	reg [2:0] pulse_reg;
	reg global_reg;
	reg [5:0] sel_reg;
	reg [2:0] acc_reg;
	reg [3:0] state_reg;
	reg [19:0] sAddr_reg;
	reg sCe_reg;
	reg sWe_reg;
	reg sOe_reg;
	reg [7:0] sOut_reg;
	reg sDoe_reg;
	reg busy_reg;
	reg [15:0] rdNext;
	reg [3:0] stateNext;
	wire [2:0] gbIdx;
	wire [10:0] gbAddend;
	wire [10:0] delaySum;
	wire wrAcc;
	wire startSingle;
	wire startInit;

	assign gbIdx = hostAddr[2:0] - 3'h7;
	// Readout carries the guardband of the group the delay belongs to.
	assign gbAddend = gb_reg[rawDelayGroup * 14 +: 11];
	assign delaySum = rawDelay + gbAddend;
	assign wrAcc = hostWrStrobe && hostAddr == `RXDSR_ADDR_ACCESS_CTRL;
	// Only with test access granted does the host drive the SRAM.
	assign startSingle = wrAcc && hostWrData[1:0] == 2'b01 &&
		linkCtl_reg[1] && state_reg == ST_IDLE;
	assign startInit = wrAcc && hostWrData[1:0] == 2'b00 &&
		linkCtl_reg[1] && state_reg == ST_IDLE;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rdNext = 16'h0000;
		if (hostAddr >= `RXDSR_ADDR_GB_FIRST && hostAddr <= `RXDSR_ADDR_GB_LAST) begin
			rdNext = {2'b00, gb_reg[gbIdx * 14 +: 14]};
		end else begin
			case (hostAddr)
				`RXDSR_ADDR_ACCESS_CTRL: rdNext = {10'h000, acc_reg[2], 3'h0, acc_reg[1:0]};
				`RXDSR_ADDR_DATA: rdNext = {8'h00, data_reg};
				`RXDSR_ADDR_DELAY: rdNext = delay_reg;
				`RXDSR_ADDR_LINKNUM: rdNext = {7'h00, linkCtl_reg, link_reg};
				`RXDSR_ADDR_ADR_HIGH: rdNext = {12'h000, adrHigh_reg};
				`RXDSR_ADDR_ADR_LOW: rdNext = adrLow_reg;
				`RXDSR_ADDR_CONFIG: rdNext = {7'h00, cfg_reg[5], 3'h0, cfg_reg[4:0]};
				`RXDSR_ADDR_DELAY_SEL: rdNext = {10'h000, sel_reg};
				default: rdNext = 16'h0000;
			endcase
		end
	end

	// ----------------------------------------
	// Host registers
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdData_reg <= 16'h0000;
			rdValid_reg <= 1'b0;
			delay_reg <= `RXDSR_RST_DELAY;
			link_reg <= 4'h0;
			linkCtl_reg <= 5'h00;
			gb_reg <= {8{`RXDSR_RST_GB}};
			adrHigh_reg <= 4'h0;
			adrLow_reg <= 16'h0000;
			cfg_reg <= 6'h00;
			pulse_reg <= 3'h0;
			global_reg <= 1'b0;
			sel_reg <= 6'h00;
			acc_reg <= 3'h0;
		end else begin
			rdData_reg <= rdNext;
			rdValid_reg <= hostRdStrobe;
			// Sampled every cycle so a new selection shows up within two edges.
			delay_reg <= {{5{delaySum[10]}}, delaySum};
			link_reg <= rawDelayLink;
			pulse_reg <= 3'h0;
			global_reg <= 1'b0;
			if (hostWrStrobe) begin
				if (hostAddr >= `RXDSR_ADDR_GB_FIRST && hostAddr <= `RXDSR_ADDR_GB_LAST) begin
					gb_reg[gbIdx * 14 +: 14] <= hostWrData[13:0];
				end
				case (hostAddr)
					`RXDSR_ADDR_ACCESS_CTRL: begin
						acc_reg <= {hostWrData[`RXDSR_BIT_DIR], hostWrData[1:0]};
					end
					`RXDSR_ADDR_LINKNUM: begin
						linkCtl_reg <= hostWrData[8:4];
					end
					`RXDSR_ADDR_ADR_HIGH: begin
						adrHigh_reg <= hostWrData[3:0];
					end
					`RXDSR_ADDR_ADR_LOW: begin
						adrLow_reg <= hostWrData;
					end
					`RXDSR_ADDR_CONFIG: begin
						// Bits 7:5 are strobes; they read back as zero.
						cfg_reg <= {hostWrData[`RXDSR_BIT_OPT], hostWrData[4:0]};
						pulse_reg <= hostWrData[7:5];
						global_reg <= &hostWrData[7:5];
					end
					`RXDSR_ADDR_DELAY_SEL: begin
						sel_reg <= hostWrData[5:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// SRAM access engine
	// ----------------------------------------
	always @* begin
		stateNext = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (startSingle) begin
					stateNext = ST_ACC;
				end else if (startInit) begin
					stateNext = ST_INIT;
				end
			end
			ST_ACC: stateNext = ST_CAP;
			ST_CAP: stateNext = ST_IDLE;
			ST_INIT: begin
				if (sAddr_reg == memLast(cfg_reg[2:0]) || !linkCtl_reg[1]) begin
					stateNext = ST_IDLE;
				end
			end
			default: stateNext = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			data_reg <= 8'h00;
			sAddr_reg <= 20'h00000;
			sCe_reg <= 1'b1;
			sWe_reg <= 1'b1;
			sOe_reg <= 1'b1;
			sOut_reg <= 8'h00;
			sDoe_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= stateNext;
			busy_reg <= stateNext != ST_IDLE;
			if (hostWrStrobe && hostAddr == `RXDSR_ADDR_DATA) begin
				data_reg <= hostWrData[7:0];
			end
			case (state_reg)
				ST_IDLE: begin
					sCe_reg <= 1'b1;
					sWe_reg <= 1'b1;
					sOe_reg <= 1'b1;
					sDoe_reg <= 1'b1;
					if (startSingle) begin
						// Address and data are taken as they stand now.
						sAddr_reg <= {adrHigh_reg, adrLow_reg};
						sOut_reg <= data_reg;
						sCe_reg <= 1'b0;
						sWe_reg <= ~hostWrData[`RXDSR_BIT_DIR];
						sOe_reg <= hostWrData[`RXDSR_BIT_DIR];
						sDoe_reg <= ~hostWrData[`RXDSR_BIT_DIR];
					end else if (startInit) begin
						sAddr_reg <= 20'h00000;
						sOut_reg <= 8'h00;
						sCe_reg <= 1'b0;
						sWe_reg <= 1'b0;
						sDoe_reg <= 1'b0;
					end
				end
				ST_ACC: sWe_reg <= 1'b1;
				ST_CAP: begin
					if (!sOe_reg) begin
						// Fetched byte wins over a host write in the same cycle.
						data_reg <= sramDataIn;
					end
					sCe_reg <= 1'b1;
					sOe_reg <= 1'b1;
					sDoe_reg <= 1'b1;
				end
				ST_INIT: begin
					if (stateNext == ST_IDLE) begin
						sCe_reg <= 1'b1;
						sWe_reg <= 1'b1;
						sDoe_reg <= 1'b1;
					end else begin
						sAddr_reg <= sAddr_reg + 20'h00001;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hostRdData = rdData_reg;
	assign hostRdValid = rdValid_reg;
	assign delayKind = sel_reg[5:4];
	assign delayIndex = sel_reg[3:0];
	assign guardbandFlat = gb_reg;
	assign memSize = cfg_reg[2:0];
	assign memOptimise = cfg_reg[5];
	assign rxSoftReset = pulse_reg[2];
	assign txSoftReset = pulse_reg[1];
	assign counterSoftReset = pulse_reg[0];
	assign globalSoftReset = global_reg;
	assign sramTestMode = linkCtl_reg[1];
	assign sramAddr = sAddr_reg;
	assign sramCe_n = sCe_reg;
	assign sramWe_n = sWe_reg;
	assign sramOe_n = sOe_reg;
	assign sramDataOut = sOut_reg;
	assign sramDataOe_n = sDoe_reg;
	assign sramBusy = busy_reg;
endmodule

// >>> sim/rxdsr_regs_monitor.sv
`timescale 1ns/10ps
module rxdsr_regs_monitor (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// Host port
	input wire [11:0] hostAddr,
	input wire [15:0] hostWrData,
	input wire hostWrStrobe,
	input wire [15:0] hostRdData,
	input wire hostRdValid,
	// Watched outputs
	input wire [1:0] delayKind,
	input wire [2:0] memSize,
	input wire rxSoftReset,
	input wire txSoftReset,
	input wire globalSoftReset,
	input wire sramTestMode,
	input wire sramCe_n,
	input wire sramBusy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [11:0] lastAddr;
	wire wrCfg = hostWrStrobe && hostAddr == 12'h299;
	wire start = hostWrStrobe && hostAddr == 12'h280 && hostWrData[1:0] == 2'h1 && !sramBusy;
	always @(posedge sys_clk) lastAddr <= hostAddr;
	property p_dataHi; hostRdValid && lastAddr == 12'h284 |-> hostRdData[15:8] == 8'h00; endproperty
	a_dataHi: assert property (p_dataHi) else $error("data upper byte not zero");
	property p_sign; hostRdValid && lastAddr == 12'h285 |-> hostRdData[15:11] == {5{hostRdData[10]}}; endproperty
	a_sign: assert property (p_sign) else $error("delay not sign extended");
	property p_rxRst; wrCfg |=> rxSoftReset == $past(hostWrData[7]); endproperty
	a_rxRst: assert property (p_rxRst) else $error("receiver reset pulse wrong");
	property p_txRst; wrCfg |=> txSoftReset == $past(hostWrData[6]); endproperty
	a_txRst: assert property (p_txRst) else $error("transmitter reset pulse wrong");
	property p_glob; wrCfg |=> globalSoftReset == &$past(hostWrData[7:5]); endproperty
	a_glob: assert property (p_glob) else $error("global reset pulse wrong");
	property p_size; wrCfg |=> memSize == $past(hostWrData[2:0]); endproperty
	a_size: assert property (p_size) else $error("memory size not taken");
	property p_test; hostWrStrobe && hostAddr == 12'h286 |=> sramTestMode == $past(hostWrData[5]); endproperty
	a_test: assert property (p_test) else $error("test access bit not taken");
	property p_kind; hostWrStrobe && hostAddr == 12'h2AA |=> delayKind == $past(hostWrData[5:4]); endproperty
	a_kind: assert property (p_kind) else $error("delay kind not taken");
	property p_start; start && sramTestMode |=> (!sramCe_n && sramBusy)[*2] ##1 (sramCe_n && !sramBusy); endproperty
	a_start: assert property (p_start) else $error("single access timing wrong");
	property p_refuse; start && !sramTestMode |=> !sramBusy && sramCe_n; endproperty
	a_refuse: assert property (p_refuse) else $error("access made without test mode");
	c_glob: cover property (wrCfg && hostWrData[7:5] == 3'h7);
	c_read: cover property (hostRdValid && lastAddr == 12'h284);
	c_start: cover property (start && sramTestMode);
	c_init: cover property (hostWrStrobe && hostAddr == 12'h280 && hostWrData[1:0] == 2'h0 && sramTestMode);
endmodule
bind rxdsr_regs rxdsr_regs_monitor mon (.*);

// >>> sim/rxdsr_sram_model.sv
`timescale 1ns/10ps
module rxdsr_sram_model (
	// Clock
	input wire sys_clk,
	// Memory pins
	input wire [19:0] sramAddr,
	input wire sramCe_n,
	input wire sramWe_n,
	input wire sramOe_n,
	input wire [7:0] sramDataOut,
	output logic [7:0] sramDataIn
);
	logic [7:0] mem [0:1048575];
	bit filled [0:1048575];
	initial sramDataIn = 8'h00;
	always @(posedge sys_clk) begin
		if (!sramCe_n && !sramWe_n) begin
			mem[sramAddr] <= sramDataOut;
			filled[sramAddr] <= 1'b1;
		end
	end
	// A released bus flips every cycle, so stale data never passes for a read.
	always @(negedge sys_clk) begin
		if (!sramCe_n && !sramOe_n && filled[sramAddr]) begin
			sramDataIn <= mem[sramAddr];
		end else begin
			sramDataIn <= ~sramDataIn;
		end
	end
endmodule

// >>> sim/rx_delay_and_sram_access_regs_tb.sv
`timescale 1ns/10ps
module rx_delay_and_sram_access_regs_tb;
	logic sys_clk = '0, resetn = '0, hostWrStrobe = '0, hostRdStrobe = '0, hostRdValid;
	logic [11:0] hostAddr = '0;
	logic [15:0] hostWrData = '0, hostRdData;
	logic [10:0] rawDelay = '0;
	logic [3:0] rawDelayLink = 4'h5, delayIndex;
	logic [2:0] rawDelayGroup = '0, memSize;
	logic [1:0] delayKind;
	logic [111:0] guardbandFlat;
	logic memOptimise, rxSoftReset, txSoftReset, counterSoftReset, globalSoftReset;
	logic sramTestMode, sramCe_n, sramWe_n, sramOe_n, sramDataOe_n, sramBusy;
	logic [19:0] sramAddr;
	logic [7:0] sramDataOut, sramDataIn;
	wire [3:0] pulseSeen = {globalSoftReset, rxSoftReset, txSoftReset, counterSoftReset};
	wire [3:0] pinsSeen = {sramCe_n, sramWe_n, sramOe_n, sramDataOe_n};
	int mismatches = 0, checked = 0, cyc = 0;
	logic [15:0] cfgs [4] = '{16'h00E0, 16'h0080, 16'h0040, 16'h0020};
	logic [3:0] pulses [4] = '{4'hF, 4'h4, 4'h2, 4'h1};
	rxdsr_regs dut (.*);
	rxdsr_sram_model sram (.*);
	initial forever #20 sys_clk = ~sys_clk;
	// A hung handshake ends the run as a failure.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 45000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		hostAddr = a;
		hostWrData = d;
		hostWrStrobe = 1'h1;
		@(negedge sys_clk);
		hostWrStrobe = 1'h0;
	endtask
	task rc(input logic [11:0] a, input logic [15:0] e);
		@(negedge sys_clk);
		hostAddr = a;
		hostRdStrobe = 1'h1;
		@(negedge sys_clk);
		hostRdStrobe = 1'h0;
		chk(hostRdValid ? hostRdData : 16'hDEAD, e);
	endtask
	task wait_idle(input logic [19:0] a);
		for (int i = 0; i < 20 && sramBusy !== 1'h0; i++) begin
			if (!sramCe_n) chk(sramAddr[15:0], a[15:0]);
			if (!sramCe_n) chk({12'h0, sramAddr[19:16]}, {12'h0, a[19:16]});
			@(negedge sys_clk);
		end
		chk({15'h0, sramBusy}, 16'h0000);
	endtask
	task t_reset;
		rc(12'h285, 16'h0004);
		rc(12'h28E, 16'h0004);
		rc(12'h284, 16'h0000);
		rc(12'h2FF, 16'h0000);
		$display("reset test done");
	endtask
	task t_delay;
		wr(12'h28A, 16'hFFFF);
		rc(12'h28A, 16'h3FFF);
		chk({2'h0, guardbandFlat[3 * 14 +: 14]}, 16'h3FFF);
		wr(12'h28A, 16'h0010);
		rawDelayGroup = 3'h3;
		rawDelay = 11'h7FB;
		rc(12'h285, 16'h000B);
		rawDelay = 11'h7EC;
		rc(12'h285, 16'hFFFC);
		$display("delay test done");
	endtask
	task t_link;
		for (int k = 0; k < 4; k++) begin
			wr(12'h2AA, {10'h0, k[1:0], 4'h3});
			chk({10'h0, delayKind, delayIndex}, {10'h0, k[1:0], 4'h3});
		end
		rc(12'h286, 16'h0005);
		wr(12'h286, 16'h0020);
		rc(12'h286, 16'h0025);
		$display("link test done");
	endtask
	task t_sram;
		int n;
		wr(12'h297, 16'hFFFA);
		rc(12'h297, 16'h000A);
		wr(12'h298, 16'h1234);
		wr(12'h284, 16'hFF5A);
		rc(12'h284, 16'h005A);
		// Direction bit set writes the data register out, clear reads it back.
		wr(12'h280, 16'h0021);
		chk({4'h0, pinsSeen, sramDataOut}, 16'h025A);
		wait_idle(20'hA1234);
		rc(12'h280, 16'h0021);
		wr(12'h284, 16'h0000);
		wr(12'h280, 16'h0001);
		chk({4'h0, pinsSeen, sramDataOut}, 16'h0500);
		wait_idle(20'hA1234);
		rc(12'h284, 16'h005A);
		wr(12'h297, 16'h0000);
		wr(12'h298, 16'h7FFF);
		wr(12'h280, 16'h0000);
		chk({4'h0, pinsSeen, sramDataOut}, 16'h0200);
		chk(sramAddr[15:0], 16'h0000);
		n = 0;
		while (sramBusy === 1'h1 && n < 40000) begin
			n++;
			@(negedge sys_clk);
		end
		chk(n[15:0], 16'h8000);
		wr(12'h284, 16'h00FF);
		wr(12'h280, 16'h0001);
		wait_idle(20'h07FFF);
		rc(12'h284, 16'h0000);
		wr(12'h286, 16'h0000);
		wr(12'h280, 16'h0001);
		chk({15'h0, sramBusy}, 16'h0000);
		$display("sram test done");
	endtask
	task t_cfg;
		for (int k = 0; k < 4; k++) begin
			wr(12'h299, cfgs[k]);
			chk({12'h0, pulseSeen}, {12'h0, pulses[k]});
		end
		wr(12'h299, 16'h0105);
		rc(12'h299, 16'h0105);
		chk({15'h0, memOptimise}, 16'h0001);
		for (int k = 0; k < 6; k++) begin
			wr(12'h299, k[15:0]);
			chk({13'h0, memSize}, k[15:0]);
		end
		$display("config test done");
	endtask
	task tally_and_finish;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge sys_clk);
		resetn = 1'h1;
		t_reset;
		t_delay;
		t_link;
		t_sram;
		t_cfg;
		tally_and_finish;
	end
endmodule
